// ==== pkg/vsq_pkg.sv ====
// Shared constants, state codes and carrier structs for the mode and status sequencer.
// Assumes a single 40 MHz clock and comparator results already reduced to logic levels.
`default_nettype none
package vsq_pkg;
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned US_CYC = CLK_FREQ_HZ / 1_000_000;
  localparam logic [5:0] DIV_LAST = 6'(US_CYC - 1);
  // Times in microseconds, counted on the 1 us tick
  localparam int unsigned BOOT_TIME_US = 20;
  localparam int unsigned PG_BLANK_US = 20;
  localparam int unsigned PG_DELAY_US = 5000;
  localparam logic [7:0] BOOT_TICKS = 8'(BOOT_TIME_US);
  localparam logic [7:0] BLANK_TICKS = 8'(PG_BLANK_US);
  localparam logic [5:0] P2_SETTLE = 6'h20;
  // Wishbone byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic CTRL_RUN_RESET = 1'b1;

  typedef enum logic [6:0] {
    ST_SHDN = 7'h01,
    ST_START = 7'h02,
    ST_BOOT = 7'h04,
    ST_TOVID = 7'h08,
    ST_NORM = 7'h10,
    ST_FALLB = 7'h20,
    ST_SOFTSHUT = 7'h40
  } vsq_state_t;

  typedef struct packed {
    logic shdn_n;
    logic deep_sleep_select;
    logic power_state_ind_n;
    logic system_rails_good_in;
    logic fb_at_boot;
    logic fb_under_lower;
    logic fb_over_upper;
    logic fb_regulated;
    logic fb_below_half;
    logic slew_active;
    logic slew_down;
    logic ramp_down_done;
    logic thermistor_below;
    logic phase2_sense_off;
    logic ontime_diff_over;
    logic phase2_high_gate;
  } vsq_in_t;

  typedef struct packed {
    vsq_state_t st;
    logic [5:0] div;
    logic tick;
    logic [7:0] tmr;
    logic [12:0] arm;
    logic armed;
    logic clk_n;
    logic pg_oe;
    logic ph_oe;
    logic hot_oe;
    logic p2_act;
    logic skip;
    logic slow;
    logic tgt_boot;
    logic power_monitor_out;
    logic ub;
    logic [5:0] p2cnt;
    logic p2_prev;
    logic run_en;
    logic ack;
    logic [31:0] dat;
  } vsq_regs_t;

  localparam vsq_regs_t REGS_RESET = '{st: ST_SHDN, clk_n: 1'b1, pg_oe: 1'b1, ph_oe: 1'b1,
                                       power_monitor_out: 1'b1, run_en: CTRL_RUN_RESET, default: '0};
endpackage : vsq_pkg
`default_nettype wire

// ==== src/vsq_sync.sv ====
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/10ps
`default_nettype none
module vsq_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule : vsq_sync
`default_nettype wire

// ==== src/vsq_sequencer.sv ====
// Mode selection and power-good, clock-enable and phase-health sequencing.
// Assumes analog comparators deliver levels; open-drain pins are resolved outside.
// Contract
// - Power-good low until 5ms after clock-enable
// - Power-good low in soft-shutdown and shutdown
// - Power-good released during slew plus 20us
// - Upper limit blanked on skip-mode downward slews
// - Mode decoded from deep-sleep and power-state
// - Power-state low with deep-sleep low gives 1-phase forced PWM
// - Startup and boot hold use 2-phase skip
// - Soft-shutdown and boot-to-code use 2-phase PWM
// - Phase two disabled by configuration stays off
// - Thermal alert follows comparator, released in shutdown
// - Phase-health low on over 40% imbalance
// - Phase-health low in shutdown or configured off
// - Phase-health released during slew or phase off
// - Phase-health released for 32 phase-two pulses
// - Phase-health released while feedback below 0.5V
// - Rails low holds boot, clock-enable high
// - Rails good releases code target, clock-enable
// - Rails fall: clock-enable high, slow slew back
// - Stay at boot until rails return
// - Power monitor pulled down in shutdown
// - Clock-enable low after boot time period
`timescale 1ns/10ps
`default_nettype none
module vsq_sequencer #(
  parameter int unsigned PG_DELAY_US = vsq_pkg::PG_DELAY_US
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire vsq_pkg::vsq_in_t i_sense,
  input wire logic i_power_good_pin,
  output logic o_power_good_out,
  output logic o_power_good_oe,
  input wire logic i_phase_health_pin,
  output logic o_phase_health_out,
  output logic o_phase_health_oe,
  input wire logic i_thermal_alert_pin,
  output logic o_thermal_alert_n,
  output logic o_thermal_alert_oe,
  output logic o_cpu_clock_allow_n,
  output logic o_power_monitor_out,
  output logic o_phase2_active,
  output logic o_skip_mode,
  output logic o_slew_div8,
  output logic o_target_boot
);
  localparam logic [12:0] PG_DLY = 13'(PG_DELAY_US);

  vsq_pkg::vsq_in_t s;
  vsq_pkg::vsq_regs_t st_reg;
  vsq_pkg::vsq_regs_t st_next;
  logic run;
  logic boot_done;
  logic blank_done;
  logic p2_pulse;
  logic low_force;
  logic req;
  logic [31:0] status;

  // Comparator outputs may toggle on any edge of the analog loop
  vsq_sync #(.WIDTH($bits(vsq_pkg::vsq_in_t))) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_d(i_sense),
    .o_q(s)
  );

  always_comb begin
    st_next = st_reg;
    run = s.shdn_n & st_reg.run_en;
    boot_done = (st_reg.tmr >= vsq_pkg::BOOT_TICKS);
    blank_done = (st_reg.tmr >= vsq_pkg::BLANK_TICKS);
    p2_pulse = s.phase2_high_gate & ~st_reg.p2_prev;
    req = i_wb_cyc & i_wb_stb & ~st_reg.ack;
    status = 32'({st_reg.armed, i_thermal_alert_pin, i_phase_health_pin, i_power_good_pin,
                  st_reg.clk_n, st_reg.skip, st_reg.p2_act, st_reg.st});

    // One microsecond tick
    st_next.tick = (st_reg.div == vsq_pkg::DIV_LAST);
    st_next.div = st_next.tick ? 6'h00 : st_reg.div + 6'h01;

    unique case (st_reg.st)
      vsq_pkg::ST_SHDN: begin
        if (run) begin
          st_next.st = vsq_pkg::ST_START;
        end
      end
      vsq_pkg::ST_START: begin
        if (!run) begin
          st_next.st = vsq_pkg::ST_SOFTSHUT;
        end else if (s.fb_at_boot) begin
          st_next.st = vsq_pkg::ST_BOOT;
        end
      end
      vsq_pkg::ST_BOOT: begin
        if (!run) begin
          st_next.st = vsq_pkg::ST_SOFTSHUT;
        end else if (s.system_rails_good_in && boot_done) begin
          st_next.st = vsq_pkg::ST_TOVID;
        end
      end
      vsq_pkg::ST_TOVID: begin
        if (!run) begin
          st_next.st = vsq_pkg::ST_SOFTSHUT;
        end else if (!s.system_rails_good_in) begin
          st_next.st = vsq_pkg::ST_FALLB;
        end else if (!s.slew_active && s.fb_regulated) begin
          st_next.st = vsq_pkg::ST_NORM;
        end
      end
      vsq_pkg::ST_NORM: begin
        if (!run) begin
          st_next.st = vsq_pkg::ST_SOFTSHUT;
        end else if (!s.system_rails_good_in) begin
          st_next.st = vsq_pkg::ST_FALLB;
        end
      end
      vsq_pkg::ST_FALLB: begin
        if (!run) begin
          st_next.st = vsq_pkg::ST_SOFTSHUT;
        end else if (s.system_rails_good_in) begin
          st_next.st = vsq_pkg::ST_TOVID;
        end
      end
      vsq_pkg::ST_SOFTSHUT: begin
        if (s.ramp_down_done) begin
          st_next.st = vsq_pkg::ST_SHDN;
        end
      end
      default: begin
        st_next.st = vsq_pkg::ST_SHDN;
      end
    endcase

    // Shared microsecond timer: boot period on entry, blanking after each slew
    if ((st_next.st == vsq_pkg::ST_BOOT && st_reg.st != vsq_pkg::ST_BOOT) || s.slew_active) begin
      st_next.tmr = 8'h00;
    end else if (st_reg.tick && st_reg.tmr != 8'hFF) begin
      st_next.tmr = st_reg.tmr + 8'h01;
    end

    // Clock-enable is low only while heading for or holding the code target
    st_next.clk_n = !(st_next.st inside {vsq_pkg::ST_TOVID, vsq_pkg::ST_NORM});

    // Power-good arming delay from the fall of clock-enable
    if (st_next.clk_n) begin
      st_next.arm = 13'h0000;
    end else if (st_reg.tick && st_reg.arm != PG_DLY) begin
      st_next.arm = st_reg.arm + 13'h0001;
    end
    st_next.armed = !st_next.clk_n && (st_next.arm == PG_DLY);

    // Phase count and skip selection
    unique case (st_next.st)
      vsq_pkg::ST_START, vsq_pkg::ST_BOOT, vsq_pkg::ST_FALLB: begin
        st_next.p2_act = 1'b1;
        st_next.skip = 1'b1;
      end
      vsq_pkg::ST_TOVID, vsq_pkg::ST_SOFTSHUT: begin
        st_next.p2_act = 1'b1;
        st_next.skip = 1'b0;
      end
      vsq_pkg::ST_NORM: begin
        st_next.skip = s.deep_sleep_select;
        st_next.p2_act = !s.deep_sleep_select && s.power_state_ind_n;
      end
      default: begin
        st_next.p2_act = 1'b0;
        st_next.skip = 1'b0;
      end
    endcase
    if (s.phase2_sense_off) begin
      st_next.p2_act = 1'b0;
    end
    st_next.slow = st_next.st inside {vsq_pkg::ST_START, vsq_pkg::ST_SOFTSHUT, vsq_pkg::ST_FALLB};
    st_next.tgt_boot = st_next.st inside {vsq_pkg::ST_START, vsq_pkg::ST_BOOT, vsq_pkg::ST_FALLB};
    st_next.power_monitor_out = (st_next.st == vsq_pkg::ST_SHDN);

    // Upper limit blanking; a new skip-mode down slew wins over the clear
    if (s.slew_active && s.slew_down && st_reg.skip) begin
      st_next.ub = 1'b1;
    end else if (!s.slew_active && blank_done && s.fb_regulated) begin
      st_next.ub = 1'b0;
    end

    // Power-good pull-down
    low_force = (st_next.st inside {vsq_pkg::ST_SHDN, vsq_pkg::ST_START, vsq_pkg::ST_BOOT,
                                    vsq_pkg::ST_FALLB, vsq_pkg::ST_SOFTSHUT}) || !st_next.armed;
    if (low_force) begin
      st_next.pg_oe = 1'b1;
    end else if (s.slew_active || !blank_done) begin
      st_next.pg_oe = 1'b0;
    end else begin
      st_next.pg_oe = s.fb_under_lower || (s.fb_over_upper && !st_next.ub);
    end

    // Phase-two pulse count after re-enable
    st_next.p2_prev = s.phase2_high_gate;
    if (!st_next.p2_act) begin
      st_next.p2cnt = 6'h00;
    end else if (p2_pulse && st_reg.p2cnt != vsq_pkg::P2_SETTLE) begin
      st_next.p2cnt = st_reg.p2cnt + 6'h01;
    end

    // Phase-health pull-down
    // Next-state values, so the pin never pulls low for a cycle as phase two stops
    if (st_next.st == vsq_pkg::ST_SHDN || s.phase2_sense_off) begin
      st_next.ph_oe = 1'b1;
    end else if (s.slew_active || !st_next.p2_act || s.fb_below_half) begin
      st_next.ph_oe = 1'b0;
    end else if (st_next.p2cnt != vsq_pkg::P2_SETTLE) begin
      st_next.ph_oe = 1'b0;
    end else begin
      st_next.ph_oe = s.ontime_diff_over;
    end

    st_next.hot_oe = (st_next.st != vsq_pkg::ST_SHDN) && s.thermistor_below;

    // Wishbone slave: answer one cycle after the request, ack dropped next cycle
    st_next.ack = req;
    st_next.dat = 32'h0000_0000;
    if (req && i_wb_we && i_wb_adr == vsq_pkg::ADR_CTRL && i_wb_sel[0]) begin
      st_next.run_en = i_wb_dat[0];
    end
    if (req && !i_wb_we) begin
      if (i_wb_adr == vsq_pkg::ADR_CTRL) begin
        st_next.dat = {31'h0000_0000, st_reg.run_en};
      end else if (i_wb_adr == vsq_pkg::ADR_STATUS) begin
        st_next.dat = status;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= vsq_pkg::REGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_wb_dat = st_reg.dat;
  assign o_wb_ack = st_reg.ack;
  // Open-drain pins only ever drive low
  assign o_power_good_out = 1'b0;
  assign o_power_good_oe = st_reg.pg_oe;
  assign o_phase_health_out = 1'b0;
  assign o_phase_health_oe = st_reg.ph_oe;
  assign o_thermal_alert_n = 1'b0;
  assign o_thermal_alert_oe = st_reg.hot_oe;
  assign o_cpu_clock_allow_n = st_reg.clk_n;
  assign o_power_monitor_out = st_reg.power_monitor_out;
  assign o_phase2_active = st_reg.p2_act;
  assign o_skip_mode = st_reg.skip;
  assign o_slew_div8 = st_reg.slow;
  assign o_target_boot = st_reg.tgt_boot;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  chk_pg_boot_low: assert property (
    st_reg.st inside {vsq_pkg::ST_START, vsq_pkg::ST_BOOT} |-> o_power_good_oe && !st_reg.armed)
    else $error("power-good not low during startup or boot");
  chk_pg_arm_count: assert property (
    st_reg.armed |-> st_reg.arm == PG_DLY && !o_cpu_clock_allow_n)
    else $error("power-good armed before delay ran out");
  chk_pg_shut_low: assert property (
    st_reg.st inside {vsq_pkg::ST_SOFTSHUT, vsq_pkg::ST_SHDN} |-> o_power_good_oe)
    else $error("power-good released in shutdown");
  chk_pg_slew_release: assert property (
    $past(s.slew_active) && st_reg.armed && st_reg.st == vsq_pkg::ST_NORM |-> !o_power_good_oe)
    else $error("power-good driven during slew");
  chk_mode_decode: assert property (
    st_reg.st == vsq_pkg::ST_NORM |-> st_reg.skip == $past(s.deep_sleep_select))
    else $error("skip mode does not follow deep-sleep select");
  chk_boot_skip_mode: assert property (
    st_reg.st inside {vsq_pkg::ST_START, vsq_pkg::ST_BOOT} |-> st_reg.skip && st_reg.slow == (st_reg.st == vsq_pkg::ST_START))
    else $error("startup or boot not in skip mode");
  chk_shut_pwm_mode: assert property (
    st_reg.st inside {vsq_pkg::ST_SOFTSHUT, vsq_pkg::ST_TOVID} |-> !st_reg.skip)
    else $error("forced PWM missing");
  chk_cfg_single_phase: assert property (
    $past(s.phase2_sense_off) |-> !o_phase2_active && o_phase_health_oe)
    else $error("phase two active while configured off");
  chk_hot_shdn_release: assert property (
    st_reg.st == vsq_pkg::ST_SHDN |-> !o_thermal_alert_oe)
    else $error("thermal alert driven in shutdown");
  chk_ph_settle_release: assert property (
    st_reg.p2cnt != vsq_pkg::P2_SETTLE && st_reg.st != vsq_pkg::ST_SHDN
      && !$past(s.phase2_sense_off) |-> !o_phase_health_oe)
    else $error("phase-health driven before settle count");
  chk_rails_hold_boot: assert property (
    st_reg.st == vsq_pkg::ST_BOOT && !s.system_rails_good_in |=> st_reg.st != vsq_pkg::ST_TOVID && o_cpu_clock_allow_n)
    else $error("left boot without rails good");
  chk_rails_fallback: assert property (
    st_reg.st == vsq_pkg::ST_NORM && run && !s.system_rails_good_in
      |=> st_reg.st == vsq_pkg::ST_FALLB ##0 o_cpu_clock_allow_n && o_power_good_oe && o_slew_div8 && o_skip_mode)
    else $error("rails fall not handled");
  chk_power_monitor_out_shdn: assert property (
    st_reg.st == vsq_pkg::ST_SHDN |-> o_power_monitor_out)
    else $error("power monitor pulldown missing in shutdown");
  chk_ub_skip_set: assert property (
    s.slew_active && s.slew_down && st_reg.skip |=> st_reg.ub)
    else $error("upper limit not blanked on skip-mode down slew");
  chk_mode_phase: assert property (
    st_reg.st == vsq_pkg::ST_NORM && !$past(s.phase2_sense_off)
      |-> o_phase2_active == (!$past(s.deep_sleep_select) && $past(s.power_state_ind_n)))
    else $error("phase count does not follow power-state");
  chk_hot_follows: assert property (
    st_reg.st != vsq_pkg::ST_SHDN |-> o_thermal_alert_oe == $past(s.thermistor_below))
    else $error("thermal alert does not follow comparator");
  chk_ph_shdn_low: assert property (
    st_reg.st == vsq_pkg::ST_SHDN |-> o_phase_health_oe)
    else $error("phase-health released in shutdown");
  chk_ph_slew_release: assert property (
    ($past(s.slew_active) || $past(s.fb_below_half) || !o_phase2_active) && st_reg.st != vsq_pkg::ST_SHDN
      && !$past(s.phase2_sense_off) |-> !o_phase_health_oe)
    else $error("phase-health driven while it must be released");
  chk_ph_fault_low: assert property (
    st_reg.p2cnt == vsq_pkg::P2_SETTLE && o_phase2_active && st_reg.st != vsq_pkg::ST_SHDN
      && !$past(s.slew_active) && !$past(s.fb_below_half) && !$past(s.phase2_sense_off)
      |-> o_phase_health_oe == $past(s.ontime_diff_over))
    else $error("phase-health does not follow imbalance");
  chk_boot_min_time: assert property (
    st_reg.st == vsq_pkg::ST_TOVID && $past(st_reg.st) == vsq_pkg::ST_BOOT
      |-> $past(st_reg.tmr) >= vsq_pkg::BOOT_TICKS && $past(s.system_rails_good_in))
    else $error("boot period cut short");
  chk_power_monitor_out_run: assert property (
    st_reg.st != vsq_pkg::ST_SHDN |-> !o_power_monitor_out)
    else $error("power monitor pulldown left on while running");
  chk_code_clock_low: assert property (
    st_reg.st inside {vsq_pkg::ST_TOVID, vsq_pkg::ST_NORM} |-> !o_cpu_clock_allow_n && !o_target_boot)
    else $error("clock-enable or target wrong while heading for code");
  chk_fallback_stay: assert property (
    st_reg.st == vsq_pkg::ST_FALLB && run && !s.system_rails_good_in
      |=> st_reg.st == vsq_pkg::ST_FALLB && o_target_boot)
    else $error("left boot voltage without rails good");
endmodule : vsq_sequencer
`default_nettype wire

// ==== verif/vsq_plat_model.sv ====
// Platform and comparator model on the far side of the sequencer.
// Assumes the bench sets requested levels; all open-drain lines have pull-ups.
`timescale 1ns/10ps
`default_nettype none
module vsq_plat_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire vsq_pkg::vsq_in_t i_req,
  input wire logic i_phase2_active,
  input wire logic i_power_good_oe,
  input wire logic i_phase_health_oe,
  input wire logic i_thermal_alert_oe,
  output vsq_pkg::vsq_in_t o_sense,
  output logic o_power_good_pin,
  output logic o_phase_health_pin,
  output logic o_thermal_alert_pin
);
  logic [2:0] gate_cnt;
  // Gate pulses exist only while phase two switches, as on a real board
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gate_cnt <= 3'h0;
    end else begin
      gate_cnt <= i_phase2_active ? gate_cnt + 3'h1 : 3'h0;
    end
  end
  always_comb begin
    o_sense = i_req;
    // Rails stay low until the bench declares the other rails good
    o_sense.system_rails_good_in = i_req.system_rails_good_in;
    o_sense.phase2_sense_off = i_req.phase2_sense_off;
    o_sense.phase2_high_gate = gate_cnt[2];
  end
  // Released lines float up to the pull-up level
  assign o_power_good_pin = ~i_power_good_oe;
  assign o_phase_health_pin = ~i_phase_health_oe;
  assign o_thermal_alert_pin = ~i_thermal_alert_oe;
endmodule : vsq_plat_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the mode and status sequencer.
// Assumes the platform model drives the sense inputs and resolves the pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  localparam int unsigned PGD = 10;
  logic clk, rst, cyc, stb, we, ack, cn, pgo, pho, hto, power_monitor_out, p2, skp, slw, tbt, pgp, php, htp;
  logic pgd, phd, htd;
  logic [1:0] r, em;
  logic [1:0] exp_q[$];
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  vsq_pkg::vsq_in_t req, sense;
  int err_total, num_checks, n;
  vsq_sequencer #(.PG_DELAY_US(PGD)) vsq_sequencer_inst (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sense(sense),
    .i_power_good_pin(pgp), .o_power_good_out(pgd), .o_power_good_oe(pgo), .i_phase_health_pin(php),
    .o_phase_health_out(phd), .o_phase_health_oe(pho), .i_thermal_alert_pin(htp), .o_thermal_alert_n(htd),
    .o_thermal_alert_oe(hto), .o_cpu_clock_allow_n(cn), .o_power_monitor_out(power_monitor_out),
    .o_phase2_active(p2), .o_skip_mode(skp), .o_slew_div8(slw), .o_target_boot(tbt));
  vsq_plat_model vsq_plat_model_inst (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_phase2_active(p2), .i_power_good_oe(pgo),
    .i_phase_health_oe(pho), .i_thermal_alert_oe(hto), .o_sense(sense), .o_power_good_pin(pgp),
    .o_phase_health_pin(php), .o_thermal_alert_pin(htp));
  // Expected {skip, phase two} in normal operation
  function automatic logic [1:0] exp_mode(input logic d, input logic p);
    return d ? 2'b10 : {1'b0, p};
  endfunction : exp_mode
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Bounded wait, leaves the cycle count in n
  task automatic span(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : span
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    tick(20000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0;
    req = '0;
    req.power_state_ind_n = 1'b1;
    void'($urandom(66));
    tick(10);
    rst <= 1'b0;
    tick(1);
    `CHK({cn, pgo, pho, hto, power_monitor_out, p2, skp}, 7'b1110100)
    `CHK({pgd, phd, htd}, 3'b000)
    wb(1'b0, 8'h04, 32'h0);
    `CHK(q, 32'h0000_1201)
    wb(1'b1, 8'h08, 32'hFFFF_FFFF);
    wb(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h0)
    req.thermistor_below <= 1'b1;
    tick(4);
    `CHK(hto, 1'b0)
    req.shdn_n <= 1'b1;
    tick(4);
    `CHK({skp, p2, tbt, slw, hto}, 5'h1F)
    req.fb_at_boot <= 1'b1;
    tick(1000);
    `CHK({cn, pgo, skp, p2}, 4'hF)
    req.system_rails_good_in <= 1'b1;
    tick(1);
    span(cn, 1'b0);
    `CHK(n <= 6, 1'b1)
    `CHK({skp, p2, tbt}, 3'b010)
    span(pgo, 1'b0);
    `CHK(n inside {[355:450]}, 1'b1)
    req.fb_regulated <= 1'b1;
    r = 2'($urandom);
    for (int i = 0; i < 4; i++) begin
      {req.deep_sleep_select, req.power_state_ind_n} <= 2'(i) ^ r;
      exp_q.push_back(exp_mode(r[1] ^ i[1], r[0] ^ i[0]));
      tick(5);
      em = exp_q.pop_front();
      `CHK({skp, p2}, em)
      `CHK(pho, 1'b0)
    end
    {req.deep_sleep_select, req.power_state_ind_n} <= 2'b01;
    req.fb_under_lower <= 1'b1;
    req.slew_active <= 1'b1;
    tick(30);
    `CHK(pgo, 1'b0)
    req.slew_active <= 1'b0;
    tick(1);
    span(pgo, 1'b1);
    `CHK(n inside {[755:850]}, 1'b1)
    req.fb_under_lower <= 1'b0;
    req.deep_sleep_select <= 1'b1;
    tick(5);
    req.fb_regulated <= 1'b0;
    req.slew_down <= 1'b1;
    req.slew_active <= 1'b1;
    req.fb_over_upper <= 1'b1;
    tick(10);
    req.slew_active <= 1'b0;
    tick(900);
    `CHK(pgo, 1'b0)
    req.fb_regulated <= 1'b1;
    tick(8);
    `CHK(pgo, 1'b1)
    req.fb_over_upper <= 1'b0;
    req.slew_down <= 1'b0;
    {req.deep_sleep_select, req.power_state_ind_n} <= 2'b00;
    req.ontime_diff_over <= 1'b1;
    tick(6);
    `CHK({pho, p2}, 2'b00)
    req.power_state_ind_n <= 1'b1;
    tick(60);
    `CHK(pho, 1'b0)
    tick(300);
    `CHK(pho, 1'b1)
    req.fb_below_half <= 1'b1;
    tick(5);
    `CHK(pho, 1'b0)
    req.fb_below_half <= 1'b0;
    req.phase2_sense_off <= 1'b1;
    tick(5);
    `CHK({pho, p2}, 2'b10)
    req.phase2_sense_off <= 1'b0;
    req.ontime_diff_over <= 1'b0;
    req.system_rails_good_in <= 1'b0;
    tick(5);
    `CHK({cn, pgo, skp, slw, tbt, p2}, 6'h3F)
    tick(200);
    wb(1'b0, 8'h04, 32'h0);
    `CHK({cn, q[6:0]}, 8'hA0)
    req.system_rails_good_in <= 1'b1;
    tick(6);
    `CHK({cn, tbt}, 2'b00)
    wb(1'b1, 8'h00, 32'h0);
    tick(4);
    `CHK({skp, p2, pgo}, 3'b011)
    req.ramp_down_done <= 1'b1;
    tick(5);
    `CHK({power_monitor_out, pho, hto, pgo}, 4'b1101)
    wb(1'b0, 8'h04, 32'h0);
    `CHK(q[6:0], 7'h01)
    // Restart with rails already good: clock-enable waits out the boot period
    wb(1'b1, 8'h00, 32'h1);
    span(cn, 1'b0);
    `CHK(n inside {[760:805]}, 1'b1)
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
